// *** hw/genlock_reference_holdover.v ***
// timing-reference selection, genlock offset and holdover recovery
// assumes AXI4-Lite software access and synchronous reference status
// Function
// - select one of eleven timing reference sources
// - genlock offset only for external video/CW
// - vertical offset steps in whole lines
// - coarse offset steps of 0.0185 us
// - fine offset steps of 0.1 ns
// - left plus right clears all offsets
// - clamp offsets to per-format limits
// - hold last frequency on lock loss
// - fall back to internal frequency
// - satellite error over 20 ms forces jump
// - genlock drift over 20 ns allows jam
// - legal mode slews at legal rate
// - jam mode aligns phase at once
// - fast mode slews 25 times legal
// - report antenna state off/open/short/nominal
// - quality is sum of satellite correlations
// - warn when quality below threshold
// - delay error reports by configurable time
// - force shared connector to input
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "genlock_ref_defines.vh"
module genlock_reference_holdover #(
  parameter NSAT = 8,
  parameter CORR_W = 8,
  parameter TICK_DIV = 10000
) (
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire ref_present,
  input wire [31:0] phase_err,
  input wire phase_err_neg,
  input wire [NSAT*CORR_W-1:0] sat_corr,
  input wire ant_powered,
  input wire ant_over_current,
  input wire ant_under_current,
  input wire vitc_tod_selected,
  output reg [3:0] active_source,
  output reg use_internal_freq,
  output reg freeze_freq,
  output reg [1:0] slew_rate_sel,
  output reg jam_phase,
  output reg connector_is_input,
  output reg locked,
  output reg [1:0] antenna_state,
  output reg quality_warn,
  output reg error_report,
  output reg [15:0] ofs_vert,
  output reg [15:0] ofs_coarse,
  output reg [15:0] ofs_fine
);
  localparam ST_LOCKED = 2'h0;
  localparam ST_LOST = 2'h1;
  localparam ST_RECOVER = 2'h2;

  reg [3:0] src_q;
  reg loss_q;
  reg [1:0] rec_q;
  reg [1:0] fmt_q;
  reg [31:0] sel_pend_q;
  reg [15:0] thresh_q;
  reg [15:0] delay_q;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg aw_q, w_q, b_q, r_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [15:0] tick_cnt_q;
  reg tick_q;
  reg [15:0] quality_q;
  reg [15:0] lim_v, lim_c;
  reg [15:0] qsum;
  reg offset_allowed;
  reg err_raw;
  wire err_filtered;
  integer i;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready = !w_q && !b_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rresp = 2'h0;

  wire do_write = aw_q && w_q && !b_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (do_write) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        b_q <= 1'b1;
      end else if (b_q && s_axi_bready) begin
        b_q <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && !r_q) begin
      r_q <= 1'b1;
      case (s_axi_araddr)
        `REG_SELECT: s_axi_rdata <= sel_pend_q;
        `REG_OFS_VERT: s_axi_rdata <= {16'h0000, ofs_vert};
        `REG_OFS_COARSE: s_axi_rdata <= {16'h0000, ofs_coarse};
        `REG_OFS_FINE: s_axi_rdata <= {16'h0000, ofs_fine};
        `REG_STATUS: s_axi_rdata <= {20'h00000, active_source, rec_q,
          loss_q, error_report, quality_warn, antenna_state, locked};
        `REG_QUALITY: s_axi_rdata <= {16'h0000, quality_q};
        `REG_THRESH: s_axi_rdata <= {16'h0000, thresh_q};
        `REG_ERR_DELAY: s_axi_rdata <= {16'h0000, delay_q};
        `REG_TIMING_ERR: s_axi_rdata <= phase_err;
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (r_q && s_axi_rready) begin
      r_q <= 1'b0;
    end
  end

  // ****************************************************************
  // per-format offset limits
  // ****************************************************************
  always @* begin
    offset_allowed = (src_q != `SRC_INTERNAL) &&
      (src_q != `SRC_SATNAV);
    lim_v = `LIM_VERT_HD1080;
    lim_c = `LIM_COARSE_HD;
    case (src_q)
      `SRC_NTSC, `SRC_NTSC_10FID: begin
        lim_v = `LIM_VERT_NTSC;
        lim_c = `LIM_COARSE_NTSC;
      end
      `SRC_PAL: begin
        lim_v = `LIM_VERT_PAL;
        lim_c = `LIM_COARSE_PAL;
      end
      `SRC_HD_TRI: begin
        lim_v = (fmt_q == 2'h1) ? `LIM_VERT_HD720 : `LIM_VERT_HD1080;
        lim_c = `LIM_COARSE_HD;
      end
      default: begin
        lim_v = `LIM_VERT_NTSC;
        lim_c = `LIM_COARSE_NTSC;
      end
    endcase
  end

  // step a two's-complement offset by one unit and clamp
  function [15:0] step_clamp;
    input [15:0] cur;
    input left;
    input right;
    input [15:0] lim;
    reg [15:0] nxt;
    begin
      nxt = cur;
      if (right && !left)
        nxt = cur + 16'h0001;
      else if (left && !right)
        nxt = cur - 16'h0001;
      if ($signed(nxt) > $signed(lim))
        nxt = lim;
      else if ($signed(nxt) < -$signed(lim))
        nxt = -lim;
      step_clamp = nxt;
    end
  endfunction

  // ****************************************************************
  // control writes and offset adjustment
  // ctrl: bit0 confirm, bit1 left, bit2 right, bits5:4 component
  // ****************************************************************
  wire wr_ctrl = do_write && (awaddr_q == `REG_CTRL);
  wire adj_l = wr_ctrl && wdata_q[1];
  wire adj_r = wr_ctrl && wdata_q[2];
  wire [1:0] comp = wdata_q[5:4];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_pend_q <= 32'h0000_0000;
      src_q <= `SRC_INTERNAL;
      loss_q <= `LOSS_HOLD_FREQ;
      rec_q <= `REC_LEGAL;
      fmt_q <= 2'h0;
      thresh_q <= `RESET_THRESH;
      delay_q <= `RESET_ERR_DELAY;
      ofs_vert <= 16'h0000;
      ofs_coarse <= 16'h0000;
      ofs_fine <= 16'h0000;
    end else begin
      if (do_write && awaddr_q == `REG_SELECT)
        sel_pend_q <= wdata_q;
      if (do_write && awaddr_q == `REG_THRESH)
        thresh_q <= wdata_q[15:0];
      if (do_write && awaddr_q == `REG_ERR_DELAY)
        delay_q <= wdata_q[15:0];
      if (wr_ctrl && wdata_q[0]) begin
        src_q <= sel_pend_q[`SEL_SRC_LSB+3:`SEL_SRC_LSB];
        loss_q <= sel_pend_q[`SEL_LOSS_BIT];
        rec_q <= sel_pend_q[`SEL_REC_LSB+1:`SEL_REC_LSB];
        fmt_q <= sel_pend_q[`SEL_FMT_LSB+1:`SEL_FMT_LSB];
      end
      if (!offset_allowed) begin
        ofs_vert <= 16'h0000;
        ofs_coarse <= 16'h0000;
        ofs_fine <= 16'h0000;
      end else if (adj_l && adj_r) begin
        ofs_vert <= 16'h0000;
        ofs_coarse <= 16'h0000;
        ofs_fine <= 16'h0000;
      end else if (adj_l || adj_r) begin
        case (comp)
          2'h0: ofs_vert <= step_clamp(ofs_vert, adj_l, adj_r,
            lim_v);
          2'h1: ofs_coarse <= step_clamp(ofs_coarse, adj_l, adj_r,
            lim_c);
          2'h2: ofs_fine <= step_clamp(ofs_fine, adj_l, adj_r,
            `LIM_FINE);
          default: ofs_fine <= ofs_fine;
        endcase
      end
    end
  end

  // ****************************************************************
  // lock state machine and recovery
  // ****************************************************************
  wire is_satnav = (src_q == `SRC_SATNAV);
  wire big_sat_err = is_satnav && (phase_err > `JAM_SATNAV_ERR);
  wire drift_jam = !is_satnav && (phase_err > `JAM_GENLOCK_ERR);
  wire ref_ok = ref_present || (src_q == `SRC_INTERNAL);

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_LOCKED: if (!ref_ok) st_d = ST_LOST;
      ST_LOST: if (ref_ok) st_d = ST_RECOVER;
      ST_RECOVER: begin
        if (!ref_ok)
          st_d = ST_LOST;
        else if (phase_err == 32'h0000_0000)
          st_d = ST_LOCKED;
      end
      default: st_d = ST_LOST;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_LOST; // relock from scratch
      locked <= 1'b0;
      freeze_freq <= 1'b0;
      use_internal_freq <= 1'b1;
      slew_rate_sel <= 2'h0;
      jam_phase <= 1'b0;
      active_source <= `SRC_INTERNAL;
      connector_is_input <= 1'b0;
    end else begin
      st_q <= st_d;
      locked <= (st_d == ST_LOCKED);
      active_source <= src_q;
      connector_is_input <= (offset_allowed && !(src_q >= `SRC_CW_1M))
        || vitc_tod_selected;
      freeze_freq <= (st_d == ST_LOST) &&
        (loss_q == `LOSS_HOLD_FREQ);
      use_internal_freq <= (src_q == `SRC_INTERNAL) ||
        ((st_d == ST_LOST) && (loss_q == `LOSS_INTERNAL));
      jam_phase <= 1'b0;
      slew_rate_sel <= 2'h0;
      if (st_d == ST_RECOVER) begin
        if (big_sat_err)
          jam_phase <= 1'b1;
        else if (st_q == ST_LOCKED && drift_jam)
          jam_phase <= 1'b1;
        else
          case (rec_q)
            `REC_JAM: jam_phase <= (st_q == ST_LOST);
            `REC_FAST: slew_rate_sel <= 2'h2;
            default: slew_rate_sel <= 2'h1;
          endcase
      end else if (st_q == ST_LOCKED && drift_jam) begin
        jam_phase <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // antenna, quality and delayed errors
  // ****************************************************************
  always @* begin
    qsum = 16'h0000;
    for (i = 0; i < NSAT; i = i + 1)
      qsum = qsum + {{(16-CORR_W){1'b0}},
        sat_corr[i*CORR_W +: CORR_W]};
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      quality_q <= 16'h0000;
      quality_warn <= 1'b0;
      antenna_state <= 2'h0;
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
      error_report <= 1'b0;
    end else begin
      quality_q <= qsum;
      quality_warn <= is_satnav && (qsum < thresh_q);
      if (!ant_powered)
        antenna_state <= 2'h0;
      else if (ant_over_current)
        antenna_state <= 2'h2;
      else if (ant_under_current)
        antenna_state <= 2'h1;
      else
        antenna_state <= 2'h3;
      tick_q <= (tick_cnt_q == TICK_DIV[15:0] - 16'h0001);
      if (tick_cnt_q == TICK_DIV[15:0] - 16'h0001)
        tick_cnt_q <= 16'h0000;
      else
        tick_cnt_q <= tick_cnt_q + 16'h0001;
      error_report <= err_filtered;
    end
  end

  always @* begin
    err_raw = (st_q == ST_LOST) || quality_warn ||
      (is_satnav && antenna_state != 2'h3);
  end

  error_delay_filter #(
    .W(16)
  ) u_err_delay (
    .clk(clk),
    .rst(rst),
    .tick(tick_q),
    .delay(delay_q),
    .err_raw(err_raw),
    .err_out(err_filtered)
  );
endmodule
`default_nettype wire

// *** hw/genlock_ref_defines.vh ***
// constants for the timing-reference control block
// assumes a 10 MHz system clock and AXI4-Lite register access
`ifndef GENLOCK_REF_DEFINES_VH
`define GENLOCK_REF_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define REG_CTRL 8'h00
`define REG_SELECT 8'h04
`define REG_OFS_VERT 8'h08
`define REG_OFS_COARSE 8'h0c
`define REG_OFS_FINE 8'h10
`define REG_STATUS 8'h14
`define REG_QUALITY 8'h18
`define REG_THRESH 8'h1c
`define REG_ERR_DELAY 8'h20
`define REG_TIMING_ERR 8'h24

// ****************************************************************
// source codes
// ****************************************************************
`define SRC_INTERNAL 4'h0
`define SRC_SATNAV 4'h1
`define SRC_NTSC 4'h2
`define SRC_NTSC_10FID 4'h3
`define SRC_PAL 4'h4
`define SRC_HD_TRI 4'h5
`define SRC_CW_1M 4'h6
`define SRC_CW_3M58 4'h7
`define SRC_CW_4M43 4'h8
`define SRC_CW_5M 4'h9
`define SRC_CW_10M 4'ha

// ****************************************************************
// loss-of-lock response and recovery mode codes
// ****************************************************************
`define LOSS_HOLD_FREQ 1'b0
`define LOSS_INTERNAL 1'b1
`define REC_LEGAL 2'h0
`define REC_JAM 2'h1
`define REC_FAST 2'h2

// ****************************************************************
// select register field positions
// ****************************************************************
`define SEL_SRC_LSB 0
`define SEL_LOSS_BIT 4
`define SEL_REC_LSB 8
`define SEL_FMT_LSB 12

// ****************************************************************
// offset limits; coarse in 0.0185 us steps, fine in 0.1 ns steps
// ****************************************************************
`define LIM_VERT_NTSC 16'd525
`define LIM_VERT_PAL 16'd1250
`define LIM_VERT_HD1080 16'd562
`define LIM_VERT_HD720 16'd375
`define LIM_COARSE_NTSC 16'd3435
`define LIM_COARSE_PAL 16'd3459
`define LIM_COARSE_HD 16'd2004
`define LIM_FINE 16'd100

// ****************************************************************
// slew and jump thresholds, in 0.1 ns units of timing error
// ****************************************************************
`define SLEW_LEGAL_STEP 32'd1
`define SLEW_FAST_MULT 32'd25
`define JAM_GENLOCK_ERR 32'd200
`define JAM_SATNAV_ERR 32'd200000000
`define SLEW_LEGAL_DIV 24'd4687

`define RESET_ERR_DELAY 16'h000a
`define RESET_THRESH 16'h0040

`endif

// *** hw/error_delay_filter.v ***
// delays an error flag so short errors never appear
// assumes a free-running 10 MHz clock and a per-tick enable
`timescale 1ns/10ps
`default_nettype none
module error_delay_filter #(
  parameter W = 16
) (
  input wire clk,
  input wire rst,
  input wire tick,
  input wire [W-1:0] delay,
  input wire err_raw,
  output reg err_out
);
  reg [W-1:0] cnt_q;

  // ****************************************************************
  // persistence counter
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {W{1'b0}};
      err_out <= 1'b0;
    end else if (!err_raw) begin
      cnt_q <= {W{1'b0}};
      err_out <= 1'b0;
    end else if (cnt_q >= delay) begin
      err_out <= 1'b1;
    end else if (tick) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// *** dv/genlock_ref_sva.sv ***
// assertions for the timing-reference control block
// assumes it is bound onto the block's top module ports
`timescale 1ns/10ps
`default_nettype none
module genlock_ref_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ref_present,
  input wire logic vitc_tod_selected,
  input wire logic [3:0] active_source,
  input wire logic connector_is_input,
  input wire logic locked,
  input wire logic [15:0] ofs_vert,
  input wire logic [15:0] ofs_coarse,
  input wire logic [15:0] ofs_fine
);
  wire video_ref = active_source inside {[4'h2:4'h5]};
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  a_aw_refused: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
  a_ofs_zeroed: assert property (
    (active_source <= 4'h1) [*3] |-> ofs_vert == 16'h0 &&
    ofs_coarse == 16'h0 && ofs_fine == 16'h0) else $error("offset kept");
  a_fine_clamp: assert property (
    $signed(ofs_fine) <= 16'sd100 && $signed(ofs_fine) >= -16'sd100)
    else $error("fine offset out of range");
  a_vert_clamp: assert property (
    $signed(ofs_vert) <= 16'sd1250 && $signed(ofs_vert) >= -16'sd1250)
    else $error("vertical offset out of range");
  a_connector_in: assert property (
    video_ref || $past(vitc_tod_selected) |-> connector_is_input)
    else $error("connector not input");
  a_lock_drop: assert property (
    (active_source != 4'h0 && !ref_present) [*3] |-> !locked)
    else $error("lock kept without reference");
endmodule
bind genlock_reference_holdover genlock_ref_sva u_sva (.*);
`default_nettype wire

// *** dv/ref_source_model.sv ***
// behavioural external reference: video, cw or satellite signal
// assumes the bench steers presence, timing error and correlation
`timescale 1ns/10ps
`default_nettype none
module ref_source_model #(
  parameter NSAT = 8,
  parameter CORR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic on,
  input wire logic slow,
  input wire logic [31:0] err,
  input wire logic [CORR_W-1:0] corr,
  output logic ref_present,
  output logic [31:0] phase_err,
  output logic phase_err_neg,
  output logic [NSAT*CORR_W-1:0] sat_corr
);
  logic [3:0] settle_q;
  wire up = on && (!slow || settle_q == 4'hf);
  // absent signal gives a changing pattern, not a stale error
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_q <= 4'h0;
      ref_present <= 1'b0;
      phase_err <= 32'h0;
      phase_err_neg <= 1'b0;
    end else begin
      settle_q <= on ? settle_q + {3'h0, settle_q != 4'hf} : 4'h0;
      ref_present <= up;
      phase_err <= up ? err : ~phase_err;
      phase_err_neg <= up ? 1'b0 : ~phase_err_neg;
    end
  end
  assign sat_corr = {NSAT{corr}};
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the timing-reference control block
// assumes the block, its checker and the reference model compile first
`timescale 1ns/10ps
`default_nettype none
`include "genlock_ref_defines.vh"
module tb_top;
  logic clk, rst, on, slow, jam_seen, err_seen;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ref_present, phase_err_neg;
  logic ant_powered, ant_over_current, ant_under_current;
  logic vitc_tod_selected, use_internal_freq, freeze_freq, jam_phase;
  logic connector_is_input, locked, quality_warn, error_report;
  logic [1:0] s_axi_bresp, s_axi_rresp, slew_rate_sel, antenna_state;
  logic [3:0] s_axi_wstrb, active_source;
  logic [7:0] s_axi_awaddr, s_axi_araddr, corr;
  logic [15:0] ofs_vert, ofs_coarse, ofs_fine;
  logic [31:0] s_axi_wdata, s_axi_rdata, phase_err, err, d;
  logic [63:0] sat_corr;
  int errors, compares, i;
  genlock_reference_holdover #(.TICK_DIV(4)) dut (.*);
  ref_source_model model (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (jam_phase) jam_seen <= 1'b1;
    if (error_report) err_seen <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, pb;
    {pa, pw, pb} = 3'b111;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (pa || pw || pb) begin
      @(posedge clk);
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (pb && s_axi_bvalid) begin
        pb = 1'b0;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic pa, pr;
    {pa, pr} = 2'b11;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (pa || pr) begin
      @(posedge clk);
      if (pa && s_axi_arready) begin
        pa = 1'b0;
        s_axi_arvalid <= 1'b0;
      end else if (!pa && s_axi_rvalid) begin
        pr = 1'b0;
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  task automatic sel(input logic [3:0] s, input logic lo,
                     input logic [1:0] m);
    logic [3:0] prev;
    prev = active_source;
    wr(`REG_SELECT, {22'h0, m, 3'h0, lo, s});
    chk(32'(active_source), 32'(prev));
    wr(`REG_CTRL, 32'h1);
    @(posedge clk);
    chk(32'(active_source), 32'(s));
  endtask
  task automatic adj(input logic [1:0] c, input logic [1:0] rl);
    wr(`REG_CTRL, {26'h0, c, 1'b0, rl, 1'b0});
  endtask
  task automatic wait_lock(input logic v);
    for (int n = 0; n < 300 && locked !== v; n++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  // lock, lose the reference, then bring it back with error e
  task automatic recover(input logic [3:0] s, input logic lo,
                         input logic [1:0] m, input logic [31:0] e);
    sel(s, lo, m);
    err <= 32'h0;
    on <= 1'b1;
    wait_lock(1'b1);
    chk(32'(locked), 32'h1);
    on <= 1'b0;
    wait_lock(1'b0);
    chk(32'(locked), 32'h0);
    chk(32'({freeze_freq, use_internal_freq}), lo ? 32'h1 : 32'h2);
    jam_seen = 1'b0;
    err <= e;
    on <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
  initial begin
    #3000000;
    errors++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, vitc_tod_selected} = 3'b000;
    {ant_powered, ant_over_current, ant_under_current} = 3'b000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {on, slow, jam_seen, err_seen} = 4'h0;
    {s_axi_wstrb, err, corr} = {4'hf, 32'h0, 8'h08};
    errors = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`REG_THRESH, d);
    chk(d, 32'(`RESET_THRESH));
    rd(`REG_ERR_DELAY, d);
    chk(d, 32'(`RESET_ERR_DELAY));
    rd(8'h3c, d);
    chk(d, 32'h0);
    for (i = 0; i <= 10; i++) sel(i[3:0], `LOSS_HOLD_FREQ, `REC_LEGAL);
    sel(`SRC_NTSC, `LOSS_HOLD_FREQ, `REC_LEGAL);
    chk(32'(connector_is_input), 32'h1);
    adj(2'd0, 2'b10);
    chk(32'(ofs_vert), 32'h1);
    adj(2'd1, 2'b10);
    chk(32'(ofs_coarse), 32'h1);
    adj(2'd2, 2'b01);
    chk(32'(ofs_fine), 32'hffff);
    adj(2'd2, 2'b11);
    chk(32'(ofs_vert | ofs_coarse | ofs_fine), 32'h0);
    for (i = 0; i < 101; i++) adj(2'd2, 2'b10);
    chk(32'(ofs_fine), 32'd100);
    for (i = 0; i < 526; i++) adj(2'd0, 2'b01);
    chk(32'(ofs_vert), 32'hfdf3);
    sel(`SRC_INTERNAL, `LOSS_HOLD_FREQ, `REC_LEGAL);
    adj(2'd0, 2'b10);
    chk(32'(ofs_vert | ofs_coarse | ofs_fine), 32'h0);
    vitc_tod_selected <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(connector_is_input), 32'h1);
    vitc_tod_selected <= 1'b0;
    for (i = 0; i < 3; i++) begin
      recover(`SRC_NTSC, i[0], i[1:0], 32'd1000);
      if (i == 1)
        chk(32'(jam_seen), 32'h1);
      else
        chk(32'(slew_rate_sel), i == 0 ? 32'h1 : 32'h2);
      err <= 32'h0;
      wait_lock(1'b1);
    end
    jam_seen = 1'b0;
    err <= 32'd201;
    repeat (4) @(posedge clk);
    chk(32'(jam_seen), 32'h1);
    err <= 32'h0;
    wait_lock(1'b1);
    slow <= 1'b1;
    recover(`SRC_SATNAV, `LOSS_HOLD_FREQ, `REC_LEGAL, 32'd200000001);
    chk(32'(jam_seen), 32'h1);
    err <= 32'h0;
    slow <= 1'b0;
    wait_lock(1'b1);
    for (i = 0; i < 4; i++) begin
      {ant_powered, ant_over_current, ant_under_current} <=
        3'(12'h9a8 >> (i * 3));
      repeat (3) @(posedge clk);
      chk(32'(antenna_state), i);
    end
    for (i = 7; i <= 9; i += 2) begin
      corr <= i[7:0];
      repeat (20) @(posedge clk);
      rd(`REG_QUALITY, d);
      chk(d, i * 8);
      chk(32'(quality_warn), 32'(i == 7));
    end
    wr(`REG_ERR_DELAY, 32'd20);
    err_seen = 1'b0;
    on <= 1'b0;
    repeat (4) @(posedge clk);
    on <= 1'b1;
    wait_lock(1'b1);
    repeat (100) @(posedge clk);
    chk(32'(err_seen), 32'h0);
    on <= 1'b0;
    repeat (150) @(posedge clk);
    chk(32'(error_report), 32'h1);
    final_report;
  end
endmodule
`default_nettype wire
